// File: supervisor_pkg.sv
/*
  Constants, field layout and state type shared by the output and muting
  supervisor. Assumes a 40 MHz system clock and one AHB-Lite master.
*/
// Notes on behaviour
// - Check feedback 200 ms after switching; interlock.
// - Interlock leaves only on reset, fault gone.
// - Category 0 output drops at once.
// - Category 1 output drops after switch-set delay.
// - Category 1 disables restart lock; feedback selectable.
// - Active muting bypasses beam interruptions.
// - Missing monitored lamp forces outputs off.
// - Muting starts ~91 ms on, ends ~50 ms off.
// - Parallel pairs within two seconds, else lock.
// - Simultaneity lock flashes pair, shows code 7.
// - Simultaneity lock released when sensor goes inactive.
// - Sequential mode also accepts second with third.
// - Time-frame mode: 240 s limit, lock, code 3.
// - Overrun lock released once sensor goes inactive.
// - Beam mode: beam break within 240 s.
// - Beam mode: 440 ms after release, lock sensors.
// - Code 3 clears when locked sensors release.
// - Fault makes restart readiness blink at 1 Hz.
// - Feedback monitoring needs switches 2 and 4.
package supervisor_pkg;

  // Clock and tick
  localparam int CLK_PERIOD_NS   = 25;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;

  // Times in milliseconds, counted in ticks
  localparam int FB_CHECK_MS     = 200;
  localparam int SIMUL_S         = 2;
  localparam int SIMUL_MS        = SIMUL_S * 1000;
  localparam int SENSOR_LIMIT_S  = 240;
  localparam int SENSOR_LIMIT_MS = SENSOR_LIMIT_S * 1000;
  localparam int BEAM_REL_MS     = 440;
  localparam int MUTE_ON_MS      = 91;
  localparam int MUTE_OFF_MS     = 50;
  localparam int BLINK_HZ        = 1;
  localparam int BLINK_HALF_MS   = 1000 / (2 * BLINK_HZ);
  localparam int STOP_UNIT_MS    = 500;

  // Register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;

  // Control fields: bit n stands for configuration switch n+1
  localparam int CB_SW1      = 0;
  localparam int CB_SW2      = 1;
  localparam int CB_SW3      = 2;
  localparam int CB_SW4      = 3;
  localparam int CB_CAT1     = 4;
  localparam int CB_DLY_A    = 5;
  localparam int CB_DLY_B    = 7;
  localparam int CB_SEQ      = 9;
  localparam int CB_BEAM_LIM = 10;
  localparam int CB_LAMP_MON = 11;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0005;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_0fff;

  // Status fields
  localparam int SB_CAT0  = 0;
  localparam int SB_DEL   = 1;
  localparam int SB_MUTE  = 2;
  localparam int SB_LOCK  = 4;
  localparam int SB_SIMUL = 8;
  localparam int SB_DIAG  = 12;
  localparam int SB_STATE = 16;

  // Diagnostic codes
  localparam logic [3:0] DIAG_NONE  = 4'h0;
  localparam logic [3:0] DIAG_SENS  = 4'h3;
  localparam logic [3:0] DIAG_SIMUL = 4'h7;
  localparam logic [3:0] DIAG_LAMP  = 4'ha;
  localparam logic [3:0] DIAG_CFG   = 4'he;
  localparam logic [3:0] DIAG_FB    = 4'hf;

  // Output state, Gray along off, on, interlock
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_ON   = 2'b01,
    ST_LOCK = 2'b11
  } state_t;

endpackage : supervisor_pkg

// File: input_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous levels; reset clears both stages.
*/
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int W = 12
)(
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);

  logic [W-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q   <= '0;
      pin_sync <= '0;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end

endmodule : input_sync
`default_nettype wire

// File: safety_output_muting_supervisor.sv
/*
  Safety output supervisor with feedback check, two stop categories and
  muting of protection beams. Assumes AHB-Lite single word transfers, one
  clock, sensor and beam pins asynchronous (synchronised here).
*/
// The AHB-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module safety_output_muting_supervisor
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        muting_sensor_first,
  input  wire logic        muting_sensor_second,
  input  wire logic        muting_sensor_third,
  input  wire logic        muting_sensor_fourth,
  input  wire logic [3:0]  protection_beam,
  input  wire logic        feedback_monitor_input,
  input  wire logic        reset_request_input,
  input  wire logic        restart_request_input,
  input  wire logic        lamp_current_ok,
  output logic             safety_switch_output,
  output logic             delayed_stop_output,
  output logic             restart_ready_output,
  output logic             muting_lamp_output,
  output logic      [3:0]  diag_code,
  output logic      [3:0]  sensor_indicator
);

  logic [11:0] pins_s;
  logic [31:0] ctrl_q;
  logic [31:0] hrdata_q;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [15:0] tick_cnt_q;
  state_t      state_q;
  state_t      state_d;
  logic        cat0_q;
  logic        del_q;
  logic [11:0] stop_cnt_q;
  logic [1:0]  out_prev_q;
  logic        fb_run_q;
  logic [7:0]  fb_cnt_q;
  logic        rst_prev_q;
  logic        rr_prev_q;
  logic        muting_q;
  logic [6:0]  mute_cnt_q;
  logic [8:0]  rel_cnt_q;
  logic [8:0]  bl_cnt_q;
  logic        blink_q;
  logic        rdy_q;
  logic [3:0]  diag_q;
  logic [3:0]  ind_q;
  logic [3:0]  lock_w;
  logic [3:0]  simul_w;
  logic [3:0]  stop_w;

  // Pin synchronisation
  input_sync #(.W(12)) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pin_in   ({lamp_current_ok, restart_request_input, reset_request_input,
                feedback_monitor_input, protection_beam, muting_sensor_fourth,
                muting_sensor_third, muting_sensor_second, muting_sensor_first}),
    .pin_sync (pins_s)
  );

  // Named views of synchronised pins
  wire [3:0] act_w   = pins_s[3:0];
  wire [3:0] beam_w  = pins_s[7:4];
  wire       fb_s    = pins_s[8];
  wire       rst_s   = pins_s[9];
  wire       rr_s    = pins_s[10];
  wire       lamp_s  = pins_s[11];

  // Static configuration from the control register
  wire [1:0] restart_sw = {ctrl_q[CB_SW3], ctrl_q[CB_SW1]};
  wire [1:0] fb_sw      = {ctrl_q[CB_SW4], ctrl_q[CB_SW2]};
  wire       cat1       = ctrl_q[CB_CAT1];
  wire [1:0] dly_a      = ctrl_q[CB_DLY_A +: 2];
  wire [1:0] dly_b      = ctrl_q[CB_DLY_B +: 2];
  wire       seq_mode   = ctrl_q[CB_SEQ];
  wire       beam_lim   = ctrl_q[CB_BEAM_LIM];
  wire       lamp_mon   = ctrl_q[CB_LAMP_MON];

  // AHB-Lite decode; zero wait, always OKAY
  wire       addr_ph  = hsel & hready & htrans[1];
  wire       ctrl_wr  = wr_pend_q & (wr_addr_q == CTRL_OFS);
  wire [31:0] status_w = {14'h0, state_q, diag_q, simul_w, lock_w,
                          1'b0, muting_q, del_q, cat0_q};
  wire [31:0] rd_mux  = (haddr[7:0] == CTRL_OFS)   ? ctrl_q :
                        (haddr[7:0] == STATUS_OFS) ? status_w : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // Bus registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      ctrl_q    <= CTRL_RESET;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      wr_addr_q <= haddr[7:0];
      if (ctrl_wr) ctrl_q <= hwdata & CTRL_MASK;
      if (addr_ph & ~hwrite) hrdata_q <= rd_mux;
    end
  end

  // Millisecond tick from the system clock
  wire tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk_sys) begin
    if (rst | tick) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  // Fault and permission terms
  wire restart_en = (restart_sw == 2'b11) & ~cat1;
  wire fb_en      = (fb_sw == 2'b11);
  wire cfg_fault  = (restart_sw[0] ^ restart_sw[1]) | (fb_sw[0] ^ fb_sw[1]) |
                    (cat1 & (dly_a != dly_b));
  wire lamp_fault = lamp_mon & ~lamp_s;
  wire beams_ok   = (&beam_w) | muting_q;
  wire permit     = beams_ok & ~lamp_fault & ~cfg_fault;
  wire fb_expect  = ~(cat0_q | del_q);
  wire fb_due     = fb_run_q & tick & (fb_cnt_q == 8'(FB_CHECK_MS - 1));
  wire fb_fail    = fb_en & fb_due & (fb_s != fb_expect);
  wire reset_rise = rst_s & ~rst_prev_q;
  wire rr_rise    = rr_s & ~rr_prev_q;

  // Output state decision
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_OFF:  if (permit & (~restart_en | rr_rise)) state_d = ST_ON;
      ST_ON:   if (~permit) state_d = ST_OFF;
      ST_LOCK: if (reset_rise & (fb_s == fb_expect)) state_d = ST_OFF;
      default: state_d = ST_OFF;
    endcase
    if (fb_fail) state_d = ST_LOCK;
  end

  // State and category 0 output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= ST_OFF;
      cat0_q     <= 1'b0;
      rst_prev_q <= 1'b0;
      rr_prev_q  <= 1'b0;
    end else begin
      state_q    <= state_d;
      cat0_q     <= (state_d == ST_ON);
      rst_prev_q <= rst_s;
      rr_prev_q  <= rr_s;
    end
  end

  // Delayed output follows category 0 on; lags it off only in category 1
  wire [11:0] stop_lim = 12'((32'(dly_a) + 1) * STOP_UNIT_MS);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      del_q      <= 1'b0;
      stop_cnt_q <= 12'h000;
    end else if ((state_d == ST_LOCK) | cfg_fault) begin
      del_q      <= 1'b0;
    end else if (state_d == ST_ON) begin
      del_q      <= 1'b1;
      stop_cnt_q <= 12'h000;
    end else if (~cat1) begin
      del_q      <= 1'b0;
    end else if (del_q & tick) begin
      if (stop_cnt_q == stop_lim - 12'h001) del_q <= 1'b0;
      else stop_cnt_q <= stop_cnt_q + 12'h001;
    end
  end

  // Feedback check timer restarts on every output change
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_prev_q <= 2'b00;
      fb_run_q   <= 1'b0;
      fb_cnt_q   <= 8'h00;
    end else begin
      out_prev_q <= {del_q, cat0_q};
      if ({del_q, cat0_q} != out_prev_q) begin
        fb_run_q <= 1'b1;
        fb_cnt_q <= 8'h00;
      end else if (fb_due) begin
        fb_run_q <= 1'b0;
      end else if (fb_run_q & tick) begin
        fb_cnt_q <= fb_cnt_q + 8'h01;
      end
    end
  end

  // Beam release timer for beam-limited mode
  wire rel_done = (rel_cnt_q == 9'(BEAM_REL_MS));
  always_ff @(posedge clk_sys) begin
    if (rst | ~beam_lim | ~(&beam_w) | ~(|stop_w)) rel_cnt_q <= 9'h000;
    else if (tick & ~rel_done) rel_cnt_q <= rel_cnt_q + 9'h001;
  end

  // Per-sensor timing and locks
  for (genvar i = 0; i < 4; i++) begin : g_sens
    logic [17:0] t_q;
    logic        stp_q;
    logic        lk_q;
    logic        sm_q;
    wire         partner  = act_w[i ^ 1];
    wire         at_simul = (t_q == 18'(SIMUL_MS));
    wire         at_limit = (t_q == 18'(SENSOR_LIMIT_MS));
    wire         simul_set = ~seq_mode & act_w[i] & ~partner & at_simul;
    wire         over_set  = act_w[i] & at_limit & (~beam_lim | ~stp_q);
    wire         rel_set   = beam_lim & act_w[i] & rel_done;
    assign lock_w[i]  = lk_q;
    assign simul_w[i] = sm_q;
    assign stop_w[i]  = stp_q;
    always_ff @(posedge clk_sys) begin
      if (rst | ~act_w[i]) begin
        t_q   <= 18'h00000;
        stp_q <= 1'b0;
        lk_q  <= 1'b0;
        sm_q  <= 1'b0;
      end else begin
        if (tick & ~at_limit & ~stp_q) t_q <= t_q + 18'h00001;
        if (beam_lim & ~(&beam_w)) stp_q <= 1'b1;
        if (simul_set | over_set | rel_set) lk_q <= 1'b1;
        if (simul_set) sm_q <= 1'b1;
      end
    end
  end

  // Muting condition from usable sensors
  wire [3:0] use_w   = act_w & ~lock_w;
  wire mute_cond     = (use_w[0] & use_w[1]) | (use_w[2] & use_w[3]) |
                       (seq_mode & use_w[1] & use_w[2]);
  wire [6:0] mute_thr = muting_q ? 7'(MUTE_OFF_MS - 1) : 7'(MUTE_ON_MS - 1);

  // Muting entry and exit delays
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      muting_q   <= 1'b0;
      mute_cnt_q <= 7'h00;
    end else if (mute_cond == muting_q) begin
      mute_cnt_q <= 7'h00;
    end else if (tick) begin
      if (mute_cnt_q == mute_thr) begin
        muting_q   <= mute_cond;
        mute_cnt_q <= 7'h00;
      end else begin
        mute_cnt_q <= mute_cnt_q + 7'h01;
      end
    end
  end

  // Fault summary and diagnostic code
  wire any_fault = (state_q == ST_LOCK) | cfg_fault | lamp_fault | (|lock_w);
  wire [3:0] diag_d = (state_q == ST_LOCK) ? DIAG_FB :
                      cfg_fault            ? DIAG_CFG :
                      lamp_fault           ? DIAG_LAMP :
                      (|simul_w)           ? DIAG_SIMUL :
                      (|lock_w)            ? DIAG_SENS : DIAG_NONE;
  wire [3:0] flash_w = lock_w | {simul_w[2], simul_w[3], simul_w[0], simul_w[1]};

  // Half-period counter for the 1 Hz blink
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bl_cnt_q <= 9'h000;
      blink_q  <= 1'b0;
    end else if (tick) begin
      if (bl_cnt_q == 9'(BLINK_HALF_MS - 1)) begin
        bl_cnt_q <= 9'h000;
        blink_q  <= ~blink_q;
      end else begin
        bl_cnt_q <= bl_cnt_q + 9'h001;
      end
    end
  end

  // Indicator outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdy_q  <= 1'b0;
      diag_q <= DIAG_NONE;
      ind_q  <= 4'h0;
    end else begin
      rdy_q  <= any_fault ? blink_q : ((state_q == ST_OFF) & permit & restart_en);
      diag_q <= diag_d;
      ind_q  <= (flash_w & {4{blink_q}}) | (act_w & ~flash_w);
    end
  end

  assign safety_switch_output = cat0_q;
  assign delayed_stop_output  = del_q;
  assign restart_ready_output = rdy_q;
  assign muting_lamp_output   = muting_q;
  assign diag_code            = diag_q;
  assign sensor_indicator     = ind_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Checks on the output path and sensor locks
  a_fb_interlock: assert property (fb_fail |=> state_q == ST_LOCK)
    else $error("feedback mismatch did not interlock");
  a_lock_holds: assert property (state_q == ST_LOCK && !reset_rise |=> state_q == ST_LOCK)
    else $error("interlock left without reset");
  a_stop_cat0: assert property (state_q == ST_ON && !permit
    |=> !cat0_q ##1 (!cat0_q || $past(permit)))
    else $error("category 0 output not dropped");
  a_delay_holds: assert property (cat1 && del_q && !cat0_q && state_q == ST_OFF
    && !cfg_fault && !fb_fail && stop_cnt_q < stop_lim - 12'h001 && !$rose(cfg_fault)
    |=> del_q)
    else $error("delayed output dropped early");
  a_mute_bypass: assert property (state_q == ST_ON && muting_q
    && !lamp_fault && !cfg_fault && !fb_fail |=> state_q == ST_ON)
    else $error("muted beam break stopped outputs");
  a_lamp_safe: assert property (lamp_fault |=> !cat0_q)
    else $error("lamp fault left outputs on");
  a_lock_release: assert property (lock_w[0] && !act_w[0] |=> !lock_w[0] && !simul_w[0])
    else $error("sensor lock not released");
  a_code_seven: assert property (simul_w[0] && state_q != ST_LOCK
    && !cfg_fault && !lamp_fault |=> diag_q == DIAG_SIMUL)
    else $error("simultaneity lock without code 7");
  a_ready_blink: assert property ($rose(blink_q) && any_fault
    && $past(any_fault) |=> rdy_q)
    else $error("restart readiness not blinking");

  c_muting: cover property (muting_q && state_q == ST_ON && !(&beam_w));
  c_interlock: cover property (state_q == ST_LOCK ##1 state_q == ST_OFF);
  c_simul_lock: cover property ($rose(simul_w[0]));
  c_delayed_stop: cover property (cat1 && !cat0_q && $fell(del_q));

endmodule : safety_output_muting_supervisor
`default_nettype wire

// File: far_side_model.sv
/*
  Far side of the supervisor: muting sensors, protection beams, relays with
  a series feedback contact and the muting lamp. Assumes the bench drives
  the commands; relays follow the outputs after a prompt or slow lag.
*/
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic       clk_sys,
  input  wire logic       safety_switch_output,
  input  wire logic       delayed_stop_output,
  input  wire logic [3:0] sensor_cmd,
  input  wire logic [3:0] beam_cmd,
  input  wire logic       relay_weld,
  input  wire logic       relay_slow,
  input  wire logic       lamp_fitted,
  output logic      [3:0] sensor_pin,
  output logic      [3:0] protection_beam,
  output logic            feedback_monitor_input,
  output logic            lamp_current_ok
);
  logic [5:0] lag_q   = 6'h00;
  logic [1:0] relay_q = 2'b00;
  // Relays pull in and drop out after the chosen lag
  always @(posedge clk_sys) begin
    if ({safety_switch_output, delayed_stop_output} === relay_q) begin
      lag_q <= 6'h00;
    end else if (lag_q == (relay_slow ? 6'h28 : 6'h02)) begin
      relay_q <= {safety_switch_output, delayed_stop_output};
      lag_q   <= 6'h00;
    end else begin
      lag_q <= lag_q + 6'h01;
    end
  end
  // Series break contacts close only with all relays open; a weld holds one open
  assign feedback_monitor_input = ~(|relay_q) & ~relay_weld;
  assign sensor_pin             = sensor_cmd;
  assign protection_beam        = beam_cmd;
  assign lamp_current_ok        = lamp_fitted;
endmodule : far_side_model
`default_nettype wire

// File: tb_safety_output_muting_supervisor.sv
/*
  Self-checking bench for the output and muting supervisor. Assumes one
  AHB-Lite master, a 40 MHz clock and the millisecond tick shortened to 4.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_safety_output_muting_supervisor;
  import supervisor_pkg::*;
  localparam int TK = 4;
  typedef struct { int sel; logic [31:0] exp; } note_t;
  logic        clk_sys = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hr_at_edge, rnd;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [3:0]  sensor_cmd = 4'h0, beam_cmd = 4'hf, sensor_pin, protection_beam;
  logic [3:0]  diag_code, sensor_indicator;
  logic        relay_weld = 1'b0, relay_slow = 1'b0, lamp_fitted = 1'b1;
  logic        reset_request_input = 1'b0, restart_request_input = 1'b0;
  logic        hreadyout, hresp, feedback_monitor_input, lamp_current_ok;
  logic        safety_switch_output, delayed_stop_output;
  logic        restart_ready_output, muting_lamp_output;
  int          n_mismatch = 0, num_checks = 0;
  note_t       notes[$];
  note_t       nt;
  string       nm[8] = '{"hrdata", "cat0_out", "delayed_out", "mute_lamp", "diag", "ready",
                         "indicator", "hresp"};

  safety_output_muting_supervisor #(.TICK_CYCLES(TK)) i_safety_output_muting_supervisor (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .muting_sensor_first(sensor_pin[0]), .muting_sensor_second(sensor_pin[1]),
    .muting_sensor_third(sensor_pin[2]), .muting_sensor_fourth(sensor_pin[3]),
    .protection_beam(protection_beam), .feedback_monitor_input(feedback_monitor_input),
    .reset_request_input(reset_request_input), .restart_request_input(restart_request_input),
    .lamp_current_ok(lamp_current_ok), .safety_switch_output(safety_switch_output),
    .delayed_stop_output(delayed_stop_output), .restart_ready_output(restart_ready_output),
    .muting_lamp_output(muting_lamp_output), .diag_code(diag_code),
    .sensor_indicator(sensor_indicator));

  far_side_model i_far_side_model (
    .clk_sys(clk_sys), .safety_switch_output(safety_switch_output),
    .delayed_stop_output(delayed_stop_output), .sensor_cmd(sensor_cmd), .beam_cmd(beam_cmd),
    .relay_weld(relay_weld), .relay_slow(relay_slow), .lamp_fitted(lamp_fitted),
    .sensor_pin(sensor_pin), .protection_beam(protection_beam),
    .feedback_monitor_input(feedback_monitor_input), .lamp_current_ok(lamp_current_ok));

  // Clock and read data as seen at each edge
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) hr_at_edge <= hrdata;

  function automatic logic [31:0] obs(input int sel);
    case (sel)
      0:       return hr_at_edge;
      1:       return {31'h0, safety_switch_output};
      2:       return {31'h0, delayed_stop_output};
      3:       return {31'h0, muting_lamp_output};
      4:       return {28'h0, diag_code};
      6:       return {28'h0, sensor_indicator};
      7:       return {31'h0, hresp};
      default: return {31'h0, restart_ready_output};
    endcase
  endfunction : obs

  task automatic cmp_reg(input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h saw %h", nm[0], e, s);
    end
  endtask : cmp_reg

  task automatic cmp_pin(input int sel, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h saw %h", nm[sel], e, s);
    end
  endtask : cmp_pin

  // Monitor takes the oldest note and compares it with what is seen now
  initial forever begin
    wait (notes.size() > 0);
    nt = notes.pop_front();
    if (nt.sel == 0) cmp_reg(nt.exp, obs(0));
    else cmp_pin(nt.sel, nt.exp, obs(nt.sel));
  end

  task automatic chk(input int sel, input logic [31:0] e);
    #1;
    notes.push_back('{sel, e});
  endtask : chk

  task automatic wait_for(input int sel, input logic [31:0] v, input int max);
    int n;
    n = 0;
    #1;
    while (obs(sel) !== v && n < max) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk(sel, v);
  endtask : wait_for

  task automatic stay(input int sel, input logic [31:0] v, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (obs(sel) !== v) break;
    end
    chk(sel, v);
  endtask : stay

  // Single AHB-Lite word transfer; read data checked at the data phase edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    if (!wr) chk(0, d);
    chk(7, 32'h0);
  endtask : bus

  task automatic drive(input logic [3:0] s, input logic [3:0] b);
    @(posedge clk_sys);
    sensor_cmd <= s;
    beam_cmd   <= b;
  endtask : drive

  task automatic press(input bit rs);
    @(posedge clk_sys);
    if (rs) reset_request_input <= 1'b1;
    else restart_request_input <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset_request_input   <= 1'b0;
    restart_request_input <= 1'b0;
  endtask : press

  task automatic blink();
    logic v;
    v = restart_ready_output;
    wait_for(5, {31'h0, ~v}, 510 * TK);
    stay(5, {31'h0, ~v}, 495 * TK);
    wait_for(5, {31'h0, v}, 10 * TK);
  endtask : blink

  task automatic final_report();
    #5;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Watchdog against a hang
  initial begin
    #(60000 * 25);
    n_mismatch++;
    final_report();
  end

  // Main sequence
  initial begin
    rnd = $urandom(56);
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, 32'h0, CTRL_RESET);
    bus(1, 32'h8, $urandom);
    bus(0, 32'h8, 32'h0);
    bus(1, 32'h4, $urandom);
    bus(0, 32'h4, 32'h0);
    rnd = ($urandom & 32'hffff_fffe) | 32'h0000_0004; // Switches 1/3 differ: outputs stay off
    bus(1, 32'h0, rnd);
    bus(0, 32'h0, rnd & CTRL_MASK);
    bus(1, 32'h0, CTRL_RESET);
    stay(1, 0, 100);
    chk(5, 1);
    press(0);
    wait_for(1, 1, 60);
    drive(4'h0, 4'hb);
    repeat (4) @(posedge clk_sys);
    chk(1, 0);
    drive(4'h0, 4'hf);
    press(0);
    wait_for(1, 1, 60);
    drive(4'h3, 4'hf);
    stay(3, 0, 80 * TK);
    wait_for(3, 1, 20 * TK);
    drive(4'h3, 4'h0);
    stay(1, 1, 100);
    drive(4'h3, 4'hf);
    drive(4'h0, 4'hf);
    stay(3, 1, 45 * TK);
    wait_for(3, 0, 10 * TK);
    bus(1, 32'h0, 32'h205);
    drive(4'h6, 4'hf);
    wait_for(3, 1, 100 * TK);
    drive(4'h0, 4'hf);
    wait_for(3, 0, 60 * TK);
    bus(1, 32'h0, CTRL_RESET);
    drive(4'h1, 4'hf);
    stay(4, 0, 1990 * TK);
    wait_for(4, DIAG_SIMUL, 20 * TK);
    wait_for(6, 4'h3, 510 * TK);
    wait_for(6, 4'h0, 510 * TK);
    drive(4'h3, 4'hf);
    stay(3, 0, 200 * TK);
    drive(4'h0, 4'hf);
    wait_for(4, 0, 40);
    chk(6, 4'h0);
    bus(1, 32'h0, 32'h805);
    lamp_fitted <= 1'b0;
    wait_for(1, 0, 40);
    chk(4, DIAG_LAMP);
    blink();
    lamp_fitted <= 1'b1;
    bus(1, 32'h0, 32'h00f);
    press(1);
    press(0);
    wait_for(1, 1, 60);
    relay_slow <= 1'b1;
    relay_weld <= 1'b1;
    drive(4'h0, 4'h7);
    stay(4, 0, 190 * TK);
    wait_for(4, DIAG_FB, 20 * TK);
    bus(0, 32'h4, 32'h0003_f000);
    drive(4'h0, 4'hf);
    press(1);
    stay(4, DIAG_FB, 200);
    relay_weld <= 1'b0;
    stay(4, DIAG_FB, 100);
    press(1);
    wait_for(4, 0, 40);
    press(0);
    wait_for(1, 1, 60);
    stay(4, 0, 250 * TK);
    bus(1, 32'h0, 32'h405);
    drive(4'h3, 4'hf);
    wait_for(3, 1, 100 * TK);
    drive(4'h3, 4'he);
    repeat (20) @(posedge clk_sys);
    drive(4'h3, 4'hf);
    stay(4, 0, 430 * TK);
    wait_for(4, DIAG_SENS, 20 * TK);
    drive(4'h0, 4'hf);
    wait_for(4, 0, 40);
    wait_for(3, 0, 60 * TK);
    bus(1, 32'h0, 32'h015);
    drive(4'h0, 4'h7);
    repeat (4) @(posedge clk_sys);
    chk(1, 0);
    stay(2, 1, 490 * TK);
    wait_for(2, 0, 20 * TK);
    drive(4'h0, 4'hf);
    wait_for(2, 1, 60);
    final_report();
  end
endmodule : tb_safety_output_muting_supervisor
`default_nettype wire
